/* File: pkg/spi_port_regs.svh */
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define CTRL_OFFSET 6'h0D
`define STAT_OFFSET 6'h0E
`define DATA_OFFSET 6'h0F
`define CTRL_RESET 8'h00
`define STAT_RESET 8'h00

// ****************************************
// Control fields
// ****************************************
`define CTRL_IRQ_EN 7
`define CTRL_PORT_EN 6
`define CTRL_LSB_FIRST 5
`define CTRL_CONTROLLER 4
`define CTRL_IDLE_LEVEL 3
`define CTRL_SAMPLE_PHASE 2

// ****************************************
// Status fields
// ****************************************
`define STAT_DONE 7
`define STAT_COLL 6
`define STAT_DOUBLE 0

// ****************************************
// Timing (half serial periods, system cycles)
// ****************************************
`define HALF_DIV4 8'h02
`define HALF_DIV16 8'h08
`define HALF_DIV64 8'h20
`define HALF_DIV128 8'h40
`define BITS_PER_BYTE 4'h8

`endif

/* File: pkg/spi_port_pkg.sv */
// Types shared by the serial port design
package spi_port_pkg;

    // ****************************************
    // Controller state
    // ****************************************
    typedef enum logic [1:0] {
        CTL_IDLE,
        CTL_LEAD,
        CTL_TRAIL
    } ctl_state_type;

endpackage : spi_port_pkg

/* File: hdl/spi_controller_target_port.sv */
// Byte-wide serial port working as controller or target behind an 8-bit register port
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_regs.svh"

module spi_controller_target_port
    import spi_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic global_irq_en,
    input wire logic irq_ack,
    output logic irq_req,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic copi_in,
    output logic copi_out,
    output logic copi_oe,
    input wire logic cipo_in,
    output logic cipo_out,
    output logic cipo_oe,
    input wire logic sel_n_in,
    output logic sel_n_out,
    output logic sel_n_oe,
    input wire logic sclk_dir_out,
    input wire logic copi_dir_out,
    input wire logic cipo_dir_out,
    input wire logic sel_dir_out,
    input wire logic sel_level,
    output logic [7:0] rx_word,
    output logic rx_word_valid,
    input wire logic rx_word_ready
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [7:0] ctrl_q, ctrl_d;
    logic [2:0] sync1_q, sync1_d;
    logic [2:0] sync2_q, sync2_d;
    logic sclk_prev_q, sclk_prev_d;
    logic sel_prev_q, sel_prev_d;

    // Two stages for sclk, data-in and select; only stage two is looked at
    always_comb begin
        sync1_d = {sclk_in, (copi_in & ~ctrl_q[`CTRL_CONTROLLER])
                   | (cipo_in & ctrl_q[`CTRL_CONTROLLER]), sel_n_in};
        sync2_d = sync1_q;
        sclk_prev_d = sync2_q[2];
        sel_prev_d = sync2_q[0];
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
            sclk_prev_q <= 1'b1; // Matches the synchroniser reset, so no false edge
            sel_prev_q <= 1'b1;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sclk_prev_q <= sclk_prev_d;
            sel_prev_q <= sel_prev_d;
        end
    end

    // ****************************************
    // Registers and shifter state
    // ****************************************
    logic done_q, done_d;
    logic coll_q, coll_d;
    logic dbl_q, dbl_d;
    logic armed_q, armed_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bitcnt_q, bitcnt_d;
    logic [7:0] div_q, div_d;
    logic sclk_q, sclk_d;
    // Receive side kept apart from the send shifter; own clock is read back
    logic [7:0] rxsh_q, rxsh_d;
    logic [3:0] rxcnt_q, rxcnt_d;
    logic byte_q, byte_d;
    logic [7:0] rx_buf_q, rx_buf_d;
    ctl_state_type st_q, st_d;

    // Two-entry receive buffer towards the user side
    logic [7:0] fifo_q [0:1];
    logic [7:0] fifo_d [0:1];
    logic [1:0] fcnt_q, fcnt_d;
    logic rd_ptr_q, rd_ptr_d;

    logic is_ctl, en, sel_low, sel_rise, t_lead, t_trail, data_acc;
    logic ctl_tick, do_sample, do_shift, push, pop, busy;
    logic [7:0] half;
    logic [7:0] shift_tmp;

    // Combinational role, edge and rate decode
    always_comb begin
        is_ctl = ctrl_q[`CTRL_CONTROLLER];
        en = ctrl_q[`CTRL_PORT_EN];
        sel_low = ~sync2_q[0];
        sel_rise = sync2_q[0] & ~sel_prev_q;
        // Leading edge is away from idle level, trailing back to it
        t_lead = (sync2_q[2] != sclk_prev_q) && (sync2_q[2] != ctrl_q[`CTRL_IDLE_LEVEL]);
        t_trail = (sync2_q[2] != sclk_prev_q) && (sync2_q[2] == ctrl_q[`CTRL_IDLE_LEVEL]);
        unique case ({dbl_q, ctrl_q[1:0]})
            3'b000: half = `HALF_DIV4;
            3'b001: half = `HALF_DIV16;
            3'b010: half = `HALF_DIV64;
            3'b011: half = `HALF_DIV128;
            3'b100: half = `HALF_DIV4 >> 1;
            3'b101: half = `HALF_DIV16 >> 1;
            3'b110: half = `HALF_DIV64 >> 1;
            default: half = `HALF_DIV128 >> 1;
        endcase
        ctl_tick = (div_q == half - 8'h01);
        data_acc = (io_wr | io_rd) && (io_addr == `DATA_OFFSET);
        busy = is_ctl ? ((st_q != CTL_IDLE) || (rxcnt_q != 4'h0) || byte_q)
                      : (rxcnt_q != 4'h0);
        pop = rx_word_valid & rx_word_ready;
    end

    // Next-state of the port, apart from the synchronisers and the receive buffer
    always_comb begin
        ctrl_d = ctrl_q;
        done_d = done_q;
        coll_d = coll_q;
        dbl_d = dbl_q;
        armed_d = armed_q;
        shift_d = shift_q;
        bitcnt_d = bitcnt_q;
        div_d = div_q;
        sclk_d = sclk_q;
        rxsh_d = rxsh_q;
        rxcnt_d = rxcnt_q;
        byte_d = byte_q;
        rx_buf_d = rx_buf_q;
        st_d = st_q;
        do_sample = 1'b0;
        do_shift = 1'b0;
        push = 1'b0;
        shift_tmp = shift_q;
        // Register writes
        if (io_wr && io_addr == `CTRL_OFFSET) begin
            ctrl_d = io_wdata;
        end
        if (io_wr && io_addr == `STAT_OFFSET) begin
            dbl_d = io_wdata[`STAT_DOUBLE];
        end
        // Status read arms the clear; the following data access finishes it
        if (io_rd && io_addr == `STAT_OFFSET && (done_q || coll_q)) begin
            armed_d = 1'b1;
        end
        if (data_acc && armed_q) begin
            done_d = 1'b0;
            coll_d = 1'b0;
            armed_d = 1'b0;
        end
        if (irq_ack) begin
            done_d = 1'b0;
        end
        if (!en) begin
            st_d = CTL_IDLE;
            bitcnt_d = 4'h0;
            rxcnt_d = 4'h0;
            byte_d = 1'b0;
            sclk_d = ctrl_d[`CTRL_IDLE_LEVEL];
        end else if (is_ctl) begin
            // Select pulled low as input: drop to target role
            if (!sel_dir_out && sel_low) begin
                ctrl_d[`CTRL_CONTROLLER] = 1'b0;
                done_d = 1'b1;
                st_d = CTL_IDLE;
                bitcnt_d = 4'h0;
                rxcnt_d = 4'h0;
                byte_d = 1'b0;
            end else begin
                unique case (st_q)
                    CTL_IDLE: begin
                        sclk_d = ctrl_q[`CTRL_IDLE_LEVEL];
                        if (io_wr && io_addr == `DATA_OFFSET && !busy) begin
                            shift_d = io_wdata;
                            bitcnt_d = `BITS_PER_BYTE;
                            div_d = 8'h00;
                            st_d = CTL_LEAD;
                        end
                    end
                    CTL_LEAD: begin
                        div_d = div_q + 8'h01;
                        if (ctl_tick) begin
                            div_d = 8'h00;
                            sclk_d = ~ctrl_q[`CTRL_IDLE_LEVEL];
                            st_d = CTL_TRAIL;
                            // First bit already stands, so the first lead sets up nothing
                            do_shift = ctrl_q[`CTRL_SAMPLE_PHASE] && bitcnt_q != 4'h8;
                        end
                    end
                    default: begin
                        div_d = div_q + 8'h01;
                        if (ctl_tick) begin
                            div_d = 8'h00;
                            sclk_d = ctrl_q[`CTRL_IDLE_LEVEL];
                            bitcnt_d = bitcnt_q - 4'h1;
                            st_d = (bitcnt_q == 4'h1) ? CTL_IDLE : CTL_LEAD;
                            do_shift = !ctrl_q[`CTRL_SAMPLE_PHASE] && bitcnt_q != 4'h1;
                        end
                    end
                endcase
                // Own clock read back through the synchroniser, so it lines up with data
                if (st_q != CTL_IDLE || rxcnt_q != 4'h0) begin
                    do_sample = ctrl_q[`CTRL_SAMPLE_PHASE] ? t_trail : t_lead;
                end
            end
        end else if (sel_rise) begin
            bitcnt_d = 4'h0;
            rxcnt_d = 4'h0;
        end else if (sel_low) begin
            // Target: edges of the incoming clock drive the shifter
            if (ctrl_q[`CTRL_SAMPLE_PHASE]) begin
                do_shift = t_lead && rxcnt_q != 4'h0;
                do_sample = t_trail;
            end else begin
                do_sample = t_lead;
                do_shift = t_trail && rxcnt_q != 4'h0;
            end
        end
        // Write while shifting is refused and flagged
        if (io_wr && io_addr == `DATA_OFFSET && busy) begin
            coll_d = 1'b1;
        end else if (io_wr && io_addr == `DATA_OFFSET && !is_ctl) begin
            shift_d = io_wdata;
        end
        // Shift moves the next bit out
        if (do_shift) begin
            shift_d = ctrl_q[`CTRL_LSB_FIRST] ? {1'b0, shift_q[7:1]}
                                              : {shift_q[6:0], 1'b0};
        end
        // Sample collects into the receive shifter; eighth bit completes the byte
        if (do_sample) begin
            shift_tmp = ctrl_q[`CTRL_LSB_FIRST] ? {sync2_q[1], rxsh_q[7:1]}
                                                : {rxsh_q[6:0], sync2_q[1]};
            rxsh_d = shift_tmp;
            rxcnt_d = rxcnt_q + 4'h1;
            if (rxcnt_q == 4'h7) begin
                rxcnt_d = 4'h0;
                rx_buf_d = shift_tmp;
                push = 1'b1;
                byte_d = is_ctl;
                if (!is_ctl) done_d = 1'b1;
            end
        end
        // Controller reports only once its clock has stopped and the last bit is in
        if (is_ctl && byte_d && st_d == CTL_IDLE) begin
            done_d = 1'b1;
            byte_d = 1'b0;
        end
    end

    // Serial output word bit, pin enables, interrupt request and register read-back
    always_comb begin
        copi_out = ctrl_q[`CTRL_LSB_FIRST] ? shift_q[0] : shift_q[7];
        cipo_out = copi_out;
        copi_oe = en & is_ctl & copi_dir_out;
        cipo_oe = en & ~is_ctl & sel_low & cipo_dir_out;
        sclk_out = sclk_q;
        sclk_oe = en & is_ctl & sclk_dir_out;
        sel_n_out = sel_level;
        sel_n_oe = is_ctl & sel_dir_out;
        irq_req = ctrl_q[`CTRL_IRQ_EN] & done_q & global_irq_en;
        unique case (io_addr)
            `CTRL_OFFSET: io_rdata = ctrl_q;
            `STAT_OFFSET: io_rdata = {done_q, coll_q, 5'h00, dbl_q};
            `DATA_OFFSET: io_rdata = rx_buf_q;
            default: io_rdata = 8'h00;
        endcase
    end

    // Receive buffer: a full buffer refuses the newest byte
    always_comb begin
        fifo_d[0] = fifo_q[0];
        fifo_d[1] = fifo_q[1];
        fcnt_d = fcnt_q;
        rd_ptr_d = rd_ptr_q;
        if (push && fcnt_q != 2'h2) begin
            fifo_d[rd_ptr_q ^ fcnt_q[0]] = rx_buf_d;
        end
        fcnt_d = fcnt_q + {1'b0, push && fcnt_q != 2'h2} - {1'b0, pop};
        if (pop) rd_ptr_d = ~rd_ptr_q;
        rx_word = fifo_q[rd_ptr_q];
        rx_word_valid = (fcnt_q != 2'h0);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `CTRL_RESET;
            done_q <= 1'b0;
            coll_q <= 1'b0;
            dbl_q <= 1'b0;
            armed_q <= 1'b0;
            shift_q <= 8'h00;
            bitcnt_q <= 4'h0;
            div_q <= 8'h00;
            sclk_q <= 1'b0;
            rxsh_q <= 8'h00;
            rxcnt_q <= 4'h0;
            byte_q <= 1'b0;
            rx_buf_q <= 8'h00;
            st_q <= CTL_IDLE;
            fifo_q[0] <= 8'h00;
            fifo_q[1] <= 8'h00;
            fcnt_q <= 2'h0;
            rd_ptr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            done_q <= done_d;
            coll_q <= coll_d;
            dbl_q <= dbl_d;
            armed_q <= armed_d;
            shift_q <= shift_d;
            bitcnt_q <= bitcnt_d;
            div_q <= div_d;
            sclk_q <= sclk_d;
            rxsh_q <= rxsh_d;
            rxcnt_q <= rxcnt_d;
            byte_q <= byte_d;
            rx_buf_q <= rx_buf_d;
            st_q <= st_d;
            fifo_q[0] <= fifo_d[0];
            fifo_q[1] <= fifo_d[1];
            fcnt_q <= fcnt_d;
            rd_ptr_q <= rd_ptr_d;
        end
    end

endmodule : spi_controller_target_port

`default_nettype wire

/* File: test/spi_port_checker.sv */
// Port-level assertions for the serial port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module spi_port_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_rdata,
    input wire logic global_irq_en,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic sclk_oe,
    input wire logic copi_oe,
    input wire logic cipo_oe,
    input wire logic cipo_dir_out,
    input wire logic sel_n_in,
    input wire logic sel_n_oe,
    input wire logic sel_dir_out,
    input wire logic [7:0] rx_word,
    input wire logic rx_word_valid,
    input wire logic rx_word_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ****
    // Sequences
    // ****
    // Two cycles of control reads; the pin enables follow the control register combinationally
    sequence target_s;
        (io_addr == 6'h0D && !io_rdata[4]) [*2];
    endsequence
    sequence off_s;
        (io_addr == 6'h0D && !io_rdata[6]) [*2];
    endsequence
    // Another controller pulls select while this one drives the clock
    sequence taken_s;
        sclk_oe && !sel_dir_out && !sel_n_in;
    endsequence
    // ****
    // Assertions
    // ****
    cipo_drive_a: assert property (cipo_oe |-> cipo_dir_out)
        else $error("data out driven without its direction bit");
    target_quiet_a: assert property (target_s |-> !sclk_oe && !copi_oe && !sel_n_oe)
        else $error("target role drives a controller pin");
    port_off_a: assert property (off_s |-> !sclk_oe && !copi_oe && !cipo_oe)
        else $error("disabled port drives a pin");
    sel_plain_a: assert property (sel_n_oe |-> sel_dir_out)
        else $error("select driven while set as input");
    role_loss_a: assert property (taken_s |-> ##[1:5] !sclk_oe)
        else $error("clock still driven after select was taken");
    irq_gate_a: assert property (irq_req |-> global_irq_en)
        else $error("interrupt raised with global enable off");
    irq_clear_a: assert property (irq_ack |=> !irq_req)
        else $error("interrupt survives vector taken");
    status_zero_a: assert property (io_addr == 6'h0E |-> io_rdata[5:1] == 5'h00)
        else $error("unused status bits not zero");
    rx_hold_a: assert property (rx_word_valid && !rx_word_ready
        |=> rx_word_valid && $stable(rx_word))
        else $error("stalled receive word changed or vanished");
endmodule : spi_port_checker

bind spi_controller_target_port spi_port_checker checker_i (
    .clk_sys(clk_sys), .rstn(rstn), .io_addr(io_addr), .io_rdata(io_rdata),
    .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req),
    .sclk_oe(sclk_oe), .copi_oe(copi_oe), .cipo_oe(cipo_oe), .cipo_dir_out(cipo_dir_out),
    .sel_n_in(sel_n_in), .sel_n_oe(sel_n_oe), .sel_dir_out(sel_dir_out), .rx_word(rx_word),
    .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready)
);
`default_nettype wire

/* File: test/spi_peer_model.sv */
// Behavioural far-side target that answers one byte per selection
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic copi,
    input wire logic idle_level_sel,
    input wire logic sample_phase_sel,
    input wire logic lsb,
    input wire logic [7:0] reply,
    output logic cipo,
    output logic [7:0] got
);
    logic [7:0] tx_q;
    // ****
    // Shifting
    // ****
    // Next reply bit onto the line in the chosen order
    task automatic put();
        cipo = lsb ? tx_q[0] : tx_q[7];
        tx_q = lsb ? tx_q >> 1 : tx_q << 1;
    endtask : put
    initial begin
        cipo = 1'b0;
        tx_q = 8'h00;
        got = 8'h00;
    end
    // Release inverts the line so a stale level is never mistaken for data
    always @(sel_n) begin
        if (!sel_n) begin
            tx_q = reply;
            if (!sample_phase_sel) put();
        end else begin
            cipo = ~cipo;
        end
    end
    // Sample on one edge, set up on the other
    always @(sclk) begin
        if (!sel_n) begin
            if ((sclk != idle_level_sel) ^ sample_phase_sel) got = lsb ? {copi, got[7:1]} : {got[6:0], copi};
            else put();
        end
    end
endmodule : spi_peer_model
`default_nettype wire

/* File: test/tb_spi_controller_target_port.sv */
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_spi_controller_target_port;
    logic clk_sys, rstn, io_wr, io_rd, global_irq_en, irq_ack, rx_word_ready, irq_req;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, rx_word, c_q, reply, peer_got;
    logic rx_word_valid, sclk_out, sclk_oe, copi_out, copi_oe, cipo_out, cipo_oe, sel_n_out;
    logic sel_n_oe, peer_cipo, sclk_dir_out, copi_dir_out, cipo_dir_out, sel_dir_out;
    logic sel_level, ext_sclk, ext_copi, ext_sel, sclk_w, copi_w, cipo_w, sel_w, sclk_prev;
    int n_mismatch, total_checks, n_edge, e_mark, first_c, last_c, cyc;
    // Wire levels from each party's enable
    assign sclk_w = sclk_oe ? sclk_out : ext_sclk;
    assign copi_w = copi_oe ? copi_out : ext_copi;
    assign cipo_w = cipo_oe ? cipo_out : peer_cipo;
    assign sel_w = sel_n_oe ? sel_n_out : ext_sel;
    spi_controller_target_port dut (.clk_sys(clk_sys), .rstn(rstn), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req),
        .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .copi_in(copi_w),
        .copi_out(copi_out), .copi_oe(copi_oe), .cipo_in(cipo_w), .cipo_out(cipo_out),
        .cipo_oe(cipo_oe), .sel_n_in(sel_w), .sel_n_out(sel_n_out), .sel_n_oe(sel_n_oe),
        .sclk_dir_out(sclk_dir_out), .copi_dir_out(copi_dir_out),
        .cipo_dir_out(cipo_dir_out), .sel_dir_out(sel_dir_out), .sel_level(sel_level),
        .rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready));
    spi_peer_model peer (.sclk(sclk_w), .sel_n(sel_w), .copi(copi_w), .idle_level_sel(c_q[3]),
        .sample_phase_sel(c_q[2]), .lsb(c_q[5]), .reply(reply), .cipo(peer_cipo), .got(peer_got));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Serial clock edges counted in system cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        sclk_prev <= sclk_w;
        if (sclk_w !== sclk_prev) begin
            n_edge <= n_edge + 1;
            if (n_edge == e_mark) first_c <= cyc;
            last_c <= cyc;
        end
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk_sys);
        io_wr = 1'b0;
    endtask : wr
    // Read data is combinational, so it is taken just after the address settles
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        io_addr = a;
        io_rd = 1'b1;
        #1 d = io_rdata;
        @(negedge clk_sys);
        io_rd = 1'b0;
    endtask : rd
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rdc
    // Bounded poll; the slowest byte needs about a thousand cycles
    task automatic wait_done(output logic [7:0] s);
        s = 8'h00;
        for (int k = 0; k < 700 && !s[7]; k++) rd(6'h0E, s);
    endtask : wait_done
    // One controller byte under a fresh select; the peer answers the inverse
    task automatic xfer(input logic [7:0] tx, input logic coll, input int half);
        logic [7:0] s;
        reply = ~tx;
        @(negedge clk_sys);
        sel_level = 1'b1;
        repeat (4) @(negedge clk_sys);
        sel_level = 1'b0;
        repeat (4) @(negedge clk_sys);
        e_mark = n_edge;
        wr(6'h0F, tx);
        if (coll) wr(6'h0F, ~tx);
        wait_done(s);
        chk(s[7:6], {1'b1, coll});
        rdc(6'h0F, ~tx);
        rd(6'h0E, s);
        chk(s[7:6], 2'h0);
        chk(16'(n_edge - e_mark), 16'd16);
        chk(16'(last_c - first_c), 16'(15 * half));
        chk(peer_got, tx);
        chk(sclk_w, c_q[3]);
    endtask : xfer
    task automatic regs();
        rdc(6'h0D, 8'h00);
        rdc(6'h0E, 8'h00);
        rdc(6'h00, 8'h00);
        wr(6'h0E, 8'hFF);
        rdc(6'h0E, 8'h01);
        wr(6'h0E, 8'h00);
        wr(6'h0F, 8'h55);
        repeat (40) @(negedge clk_sys);
        rdc(6'h0E, 8'h00);
    endtask : regs
    // Every mode, bit order and rate code, one byte each
    task automatic ctrl_modes();
        int half [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
        for (int i = 0; i < 8; i++) begin
            c_q = {2'b01, i[0], 1'b1, i[1:0], i[1:0]};
            wr(6'h0D, c_q);
            wr(6'h0E, {7'h00, i[2]});
            xfer(8'hC5 ^ 8'(i * 37), 1'b0, half[i]);
        end
    endtask : ctrl_modes
    // Receiver stalls: a collision, then three bytes into a two-entry buffer
    task automatic buf_coll();
        @(negedge clk_sys);
        rx_word_ready = 1'b0;
        c_q = 8'h50;
        wr(6'h0D, c_q);
        wr(6'h0E, 8'h00);
        xfer(8'hA1, 1'b1, 2);
        xfer(8'h3B, 1'b0, 2);
        xfer(8'h6E, 1'b0, 2);
        @(negedge clk_sys);
        rx_word_ready = 1'b1;
        chk({rx_word_valid, rx_word}, {1'b1, 8'h5E});
        @(negedge clk_sys);
        chk({rx_word_valid, rx_word}, {1'b1, 8'hC4});
        @(negedge clk_sys);
        chk(rx_word_valid, 1'b0);
    endtask : buf_coll
    task automatic forced();
        @(negedge clk_sys);
        sel_dir_out = 1'b0;
        global_irq_en = 1'b1;
        wr(6'h0D, 8'hD0);
        ext_sel = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk(irq_req, 1'b1);
        rdc(6'h0D, 8'hC0);
        irq_ack = 1'b1;
        @(negedge clk_sys);
        irq_ack = 1'b0;
        rdc(6'h0E, 8'h00);
        global_irq_en = 1'b0;
        wr(6'h0D, 8'hD0);
        repeat (8) @(negedge clk_sys);
        chk(irq_req, 1'b0);
        rdc(6'h0E, 8'h80);
        ext_sel = 1'b1;
    endtask : forced
    // Off-chip controller in mode 0 with five-cycle clock phases
    task automatic tgt_bits(input logic [7:0] d, input int n, output logic [7:0] cap);
        cap = 8'h00;
        for (int b = 7; b > 7 - n; b--) begin
            ext_copi = d[b];
            repeat (5) @(negedge clk_sys);
            ext_sclk = 1'b1;
            cap = {cap[6:0], cipo_w};
            repeat (5) @(negedge clk_sys);
            ext_sclk = 1'b0;
        end
        ext_copi = ~ext_copi;
        repeat (5) @(negedge clk_sys);
    endtask : tgt_bits
    task automatic target();
        logic [7:0] cap;
        @(negedge clk_sys);
        {sclk_dir_out, copi_dir_out, cipo_dir_out} = 3'b001;
        c_q = 8'h40;
        wr(6'h0D, c_q);
        wr(6'h0F, 8'h3C);
        tgt_bits(8'hFF, 8, cap);
        rdc(6'h0E, 8'h00);
        ext_sel = 1'b0;
        tgt_bits(8'hA5, 8, cap);
        chk(cap, 8'h3C);
        rdc(6'h0E, 8'h80);
        rdc(6'h0F, 8'hA5);
        tgt_bits(8'h00, 3, cap);
        ext_sel = 1'b1;
        repeat (5) @(negedge clk_sys);
        ext_sel = 1'b0;
        tgt_bits(8'h96, 8, cap);
        rdc(6'h0E, 8'h80);
        rdc(6'h0F, 8'h96);
        ext_sel = 1'b1;
    endtask : target
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // ****
    // Main sequence
    // ****
    initial begin
        {rstn, io_wr, io_rd, irq_ack, global_irq_en, ext_sclk, ext_copi, cipo_dir_out} = '0;
        {sclk_dir_out, copi_dir_out, sel_dir_out, sel_level, ext_sel, rx_word_ready} = '1;
        {io_addr, io_wdata, c_q, reply, sclk_prev} = '0;
        {n_mismatch, total_checks, n_edge, e_mark, cyc, first_c, last_c} = '0;
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        regs();
        ctrl_modes();
        buf_coll();
        forced();
        target();
        print_verdict();
    end
    // Watchdog well beyond the expected run of some three thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
endmodule : tb_spi_controller_target_port
`default_nettype wire
